//--- common/sce_map.vh
// constants for the serial command error checker: error codes, frame limits, timing
// assumes plain Verilog-2005 includers; definitions only
`ifndef SCE_MAP_VH
`define SCE_MAP_VH
// control characters
`define SCE_ENQ 8'h05
`define SCE_EOT 8'h04
// error codes (16-bit hex as reported)
`define SCE_ERR_NONE 16'h0000
`define SCE_ERR_CMD 16'h0021
`define SCE_ERR_MON_EXEC 16'h0190
`define SCE_ERR_MON_REG 16'h0290
`define SCE_ERR_SIZE 16'h1232
`define SCE_ERR_AREA 16'h2232
`define SCE_ERR_DTYPE 16'h2432
`define SCE_ERR_UNSUP 16'h6001
`define SCE_ERR_TIMEOUT 16'h6020
`define SCE_ERR_SYNTAX 16'h6030
`define SCE_ERR_LONG 16'h6040
`define SCE_ERR_BCC 16'h6050
`define SCE_ERR_FMT 16'h7132
// limits
`define SCE_MAX_TEXT 16'h0100
`define SCE_MAX_BYTES 16'h0080
`define SCE_MAX_MON 8'h09
// inter-byte timeout: time in microseconds, cycles at 250 MHz
`define SCE_TOUT_US 500
`define SCE_CLK_MHZ 250
`define SCE_TOUT_CYC (`SCE_TOUT_US * `SCE_CLK_MHZ)
`endif

//--- logic/sce_sync.v
// three-flop synchroniser for a level from outside the clock domain
// assumes clk is the controller clock; output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sce_sync (
  input wire clk,
  input wire nrst,
  input wire d,
  output reg q
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // first stage feeds only the second
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule // sce_sync
`default_nettype wire

//--- logic/sce_timer.v
// inter-byte timeout counter for frame reception
// assumes clear pulses on each accepted byte; run high while a frame is open
`timescale 1ns/1ps
`default_nettype none
module sce_timer #(
  parameter LIMIT = 125000
) (
  input wire clk,
  input wire nrst,
  input wire run,
  input wire clear,
  output reg expired
);
  reg [31:0] cnt_r;
  // counts only while a frame is open; a byte restarts the wait
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 32'h00000000;
      expired <= 1'b0;
    end else if (!run || clear) begin
      cnt_r <= 32'h00000000;
      expired <= 1'b0;
    end else if (cnt_r == LIMIT - 1) begin
      expired <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
    end
  end
endmodule // sce_timer
`default_nettype wire

//--- logic/sce_checker.v
// serial command error checker: validates a received ASCII request frame
// assumes a byte receiver upstream giving rx_valid/rx_data one-cycle strobes on clk,
// and a memory/response stage downstream that obeys req_ok / err_valid
`timescale 1ns/1ps
`default_nettype none
`include "sce_map.vh"
// Function
// - bad data type letter gives type error
// - bit output request without dot rejected
// - address beyond assigned area gives area error
// - non-decimal address also gives area error
// - monitor number above nine rejected
// - block sub-command with bit data type gives unsupported code
// - frame reception timeout reported
// - frame needs start and end delimiters
// - frame text over 256 bytes rejected
// - block check mismatch reported
// - zero or over 128 bytes rejected
// - unknown command letter rejected
module sce_checker #(
  parameter TOUT_CYC = `SCE_TOUT_CYC,
  parameter MAREA_BYTES = 2048
) (
  input wire clk,
  input wire nrst,
  input wire rx_err,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg req_ok,
  output reg err_valid,
  output reg [15:0] err_code,
  output reg [7:0] cmd_out,
  output reg [15:0] addr_out,
  output reg [7:0] count_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_BODY = 3'd1;
  localparam ST_BCC = 3'd2;
  localparam ST_DONE = 3'd3;
  // field positions within the frame text
  localparam F_CMD = 3'd0;
  localparam F_SUB = 3'd1;
  localparam F_PCT = 3'd2;
  localparam F_DEV = 3'd3;
  localparam F_TYP = 3'd4;
  localparam F_ADR = 3'd5;
  localparam F_CNT = 3'd6;

  wire err_sync;
  wire tout;
  reg [2:0] st_r;
  reg [2:0] fld_r;
  reg [15:0] len_r;
  reg [7:0] bcc_r;
  reg [7:0] cmd_r;
  reg [7:0] sub_r;
  reg [7:0] dev_r;
  reg [7:0] typ_r;
  reg [15:0] addr_r;
  reg [15:0] cnt_r;
  reg dot_r;
  reg nondec_r;
  reg syn_r;
  reg [7:0] bcc_rx_r;

  // framing error line comes from a pin-side receiver, so synchronise it
  sce_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(rx_err),
    .q(err_sync)
  );

  sce_timer #(.LIMIT(TOUT_CYC)) u_tmr (
    .clk(clk),
    .nrst(nrst),
    .run(st_r == ST_BODY || st_r == ST_BCC),
    .clear(rx_valid),
    .expired(tout)
  );

  function is_dec;
    input [7:0] c;
    begin
      is_dec = (c >= 8'h30) && (c <= 8'h39);
    end
  endfunction

  function [7:0] lower;
    input [7:0] c;
    begin
      lower = ((c >= 8'h41) && (c <= 8'h5A)) ? (c | 8'h20) : c;
    end
  endfunction

  // bytes per item for a data type letter
  function [7:0] type_size;
    input [7:0] t;
    begin
      case (lower(t))
        8'h62: type_size = 8'h01;
        8'h77: type_size = 8'h02;
        8'h64: type_size = 8'h04;
        default: type_size = 8'h01;
      endcase
    end
  endfunction

  // final verdict, in priority order; combinational on captured fields
  reg [15:0] verdict;
  reg [7:0] c;
  reg [7:0] t;
  reg [7:0] d;
  reg [23:0] bytes;
  always @* begin
    verdict = `SCE_ERR_NONE;
    c = lower(cmd_r);
    t = lower(typ_r);
    d = lower(dev_r);
    bytes = cnt_r * type_size(typ_r);
    if (bcc_r != bcc_rx_r) begin
      verdict = `SCE_ERR_BCC;
    end else if (c != 8'h77 && c != 8'h72 && c != 8'h78 &&
                 c != 8'h79 && c != 8'h73) begin
      verdict = `SCE_ERR_CMD;
    end else if (syn_r) begin
      verdict = `SCE_ERR_SYNTAX;
    end else if (c == 8'h79 && cnt_r > {8'h00, `SCE_MAX_MON}) begin
      verdict = `SCE_ERR_MON_REG;
    end else if (c == 8'h78 && cnt_r > {8'h00, `SCE_MAX_MON}) begin
      verdict = `SCE_ERR_MON_EXEC;
    end else if (c == 8'h72 || c == 8'h77) begin
      if (t != 8'h78 && t != 8'h62 && t != 8'h77 && t != 8'h64) begin
        verdict = `SCE_ERR_DTYPE;
      end else if (t == 8'h64 && lower(sub_r) == 8'h64) begin
        verdict = `SCE_ERR_DTYPE;
      end else if (lower(sub_r) == 8'h62 && t == 8'h78) begin
        verdict = `SCE_ERR_UNSUP;
      end else if (d == 8'h71 && t == 8'h78 && !dot_r) begin
        verdict = `SCE_ERR_FMT;
      end else if (nondec_r) begin
        verdict = `SCE_ERR_AREA;
      end else if (d == 8'h6D && ({8'h00, addr_r} + bytes) > MAREA_BYTES) begin
        verdict = `SCE_ERR_AREA;
      end else if (d == 8'h71 && t == 8'h78 && addr_r > 16'h003F) begin
        // q bit slots hold 64 points, so the last part stops at 63
        verdict = `SCE_ERR_AREA;
      end else if (cnt_r == 16'h0000 || bytes > {8'h00, `SCE_MAX_BYTES}) begin
        verdict = `SCE_ERR_SIZE;
      end
    end
  end

  // frame walker: captures fields, accumulates length and block check
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      fld_r <= F_CMD;
      len_r <= 16'h0000;
      bcc_r <= 8'h00;
      bcc_rx_r <= 8'h00;
      cmd_r <= 8'h00;
      sub_r <= 8'h00;
      dev_r <= 8'h00;
      typ_r <= 8'h00;
      addr_r <= 16'h0000;
      cnt_r <= 16'h0000;
      dot_r <= 1'b0;
      nondec_r <= 1'b0;
      syn_r <= 1'b0;
      req_ok <= 1'b0;
      err_valid <= 1'b0;
      err_code <= `SCE_ERR_NONE;
      cmd_out <= 8'h00;
      addr_out <= 16'h0000;
      count_out <= 8'h00;
    end else begin
      req_ok <= 1'b0;
      err_valid <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (rx_valid) begin
            fld_r <= F_CMD;
            len_r <= 16'h0000;
            bcc_r <= 8'h00;
            // a short frame must not inherit fields of the previous one
            cmd_r <= 8'h00;
            sub_r <= 8'h00;
            dev_r <= 8'h00;
            typ_r <= 8'h00;
            addr_r <= 16'h0000;
            cnt_r <= 16'h0000;
            dot_r <= 1'b0;
            nondec_r <= 1'b0;
            syn_r <= 1'b0;
            if (rx_data == `SCE_ENQ) begin
              st_r <= ST_BODY;
            end else begin
              err_valid <= 1'b1;
              err_code <= `SCE_ERR_SYNTAX;
            end
          end
        end
        ST_BODY: begin
          if (tout) begin
            st_r <= ST_IDLE;
            err_valid <= 1'b1;
            err_code <= `SCE_ERR_TIMEOUT;
          end else if (err_sync) begin
            st_r <= ST_IDLE;
            err_valid <= 1'b1;
            err_code <= `SCE_ERR_SYNTAX;
          end else if (rx_valid) begin
            if (rx_data == `SCE_EOT) begin
              st_r <= ST_BCC;
            end else if (len_r == `SCE_MAX_TEXT) begin
              st_r <= ST_IDLE;
              err_valid <= 1'b1;
              err_code <= `SCE_ERR_LONG;
            end else if (rx_data == `SCE_ENQ) begin
              syn_r <= 1'b1;
            end else begin
              len_r <= len_r + 16'h0001;
              bcc_r <= bcc_r + rx_data;
              // field walk: cmd, sub, '%', dev, type, address ... ',' count
              case (fld_r)
                F_CMD: begin
                  cmd_r <= rx_data;
                  fld_r <= F_SUB;
                end
                F_SUB: begin
                  sub_r <= rx_data;
                  fld_r <= F_PCT;
                end
                F_PCT: begin
                  if (rx_data != 8'h25) begin
                    syn_r <= 1'b1;
                  end
                  fld_r <= F_DEV;
                end
                F_DEV: begin
                  dev_r <= rx_data;
                  fld_r <= F_TYP;
                end
                F_TYP: begin
                  typ_r <= rx_data;
                  fld_r <= F_ADR;
                end
                F_ADR: begin
                  if (rx_data == 8'h2C) begin
                    fld_r <= F_CNT;
                  end else if (rx_data == 8'h2E) begin
                    dot_r <= 1'b1;
                    addr_r <= 16'h0000;
                  end else if (is_dec(rx_data)) begin
                    addr_r <= addr_r * 16'd10 + {8'h00, rx_data - 8'h30};
                  end else begin
                    nondec_r <= 1'b1;
                  end
                end
                F_CNT: begin
                  if (is_dec(rx_data)) begin
                    cnt_r <= cnt_r * 16'd10 + {8'h00, rx_data - 8'h30};
                  end else begin
                    syn_r <= 1'b1;
                  end
                end
                default: fld_r <= F_CMD;
              endcase
            end
          end
        end
        ST_BCC: begin
          // one check byte follows the end delimiter
          if (tout) begin
            st_r <= ST_IDLE;
            err_valid <= 1'b1;
            err_code <= `SCE_ERR_TIMEOUT;
          end else if (rx_valid) begin
            bcc_rx_r <= rx_data;
            st_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_r <= ST_IDLE;
          err_code <= verdict;
          cmd_out <= lower(cmd_r);
          addr_out <= addr_r;
          count_out <= cnt_r[7:0];
          // access only on a clean verdict
          if (verdict == `SCE_ERR_NONE) begin
            req_ok <= 1'b1;
          end else begin
            err_valid <= 1'b1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // sce_checker
`default_nettype wire

//--- tb/sce_chk_sva.sv
// checker for the serial command error checker, port view only
// assumes one clock domain and async active-low reset
`timescale 1ns/1ps
`default_nettype none
module sce_chk_sva #(
  parameter int TOUT_CYC = 125000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic req_ok,
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  input wire logic [7:0] cmd_out,
  input wire logic [7:0] count_out
);
  logic open_r, eot_r;
  logic [31:0] idle_r;
  logic [15:0] txt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // frame tracker; any verdict closes the frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst || req_ok || err_valid) begin
      open_r <= 1'b0;
      eot_r <= 1'b0;
      idle_r <= '0;
      txt_r <= '0;
    end else if (rx_valid) begin
      open_r <= open_r | (rx_data == 8'h05);
      eot_r <= open_r & (eot_r | (rx_data == 8'h04));
      txt_r <= open_r ? txt_r + 16'h0001 : 16'h0000;
      idle_r <= '0;
    end else if (open_r) begin
      idle_r <= idle_r + 1;
    end
  end
  sequence s_stray;
    rx_valid && !open_r && rx_data != 8'h05;
  endsequence
  sequence s_bcc;
    rx_valid && eot_r;
  endsequence
  AST_STRAY: assert property (s_stray |=> err_valid && err_code == 16'h6030)
    else $error("stray byte not flagged");
  AST_VERDICT: assert property (s_bcc |=> !(req_ok || err_valid) ##1 (req_ok || err_valid))
    else $error("verdict not two cycles after check byte");
  AST_EXCL: assert property (!(req_ok && err_valid))
    else $error("pass and fail together");
  AST_OK1: assert property (req_ok |=> !req_ok)
    else $error("pass pulse too long");
  AST_ERR1: assert property (err_valid |=> !err_valid)
    else $error("fail pulse too long");
  // slack of a few cycles covers the timer and state register latency
  AST_TOUT: assert property (err_valid && err_code == 16'h6020 |-> idle_r >= TOUT_CYC - 3 && idle_r <= TOUT_CYC + 4)
    else $error("timeout at wrong time");
  AST_LONG: assert property (err_valid && err_code == 16'h6040 |-> txt_r == 16'h0101)
    else $error("length error at wrong byte");
  AST_OKCMD: assert property (req_ok |-> cmd_out inside {8'h77, 8'h72, 8'h78, 8'h79, 8'h73})
    else $error("pass with bad command");
  AST_OKCNT: assert property (req_ok |-> count_out != 8'h00)
    else $error("pass with zero count");
endmodule // sce_chk_sva
bind sce_checker sce_chk_sva #(.TOUT_CYC(TOUT_CYC)) chk_u (.clk(clk), .nrst(nrst),
  .rx_valid(rx_valid), .rx_data(rx_data), .req_ok(req_ok), .err_valid(err_valid),
  .err_code(err_code), .cmd_out(cmd_out), .count_out(count_out));
`default_nettype wire

//--- tb/sce_host.sv
// host model: sends request frames one byte per clock
// assumes tasks are entered at a rising edge
`timescale 1ns/1ps
`default_nettype none
module sce_host (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_err
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_err = 1'b0;
  end
  task put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
  endtask
  // idle line shows inverted last byte, never a stale copy
  task rest();
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    @(posedge clk);
  endtask
  // receiver fault level held long enough for the three-flop synchroniser
  task fault();
    rx_err <= 1'b1;
    repeat (4) @(posedge clk);
    rx_err <= 1'b0;
    @(posedge clk);
  endtask
  // text kept short, check byte is the text sum; bad spoils it
  task frame(input string t, input logic bad);
    logic [7:0] s;
    s = 8'h00;
    put(8'h05);
    for (int i = 0; i < t.len(); i++) begin
      put(t[i]);
      s = s + t[i];
    end
    put(8'h04);
    put(s ^ {7'h00, bad});
    rest();
  endtask
endmodule // sce_host
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the serial command error checker
// assumes the host model drives all receive inputs
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, rx_valid, rx_err, req_ok, err_valid;
  logic [7:0] rx_data, cmd_out, count_out;
  logic [15:0] err_code, addr_out;
  int n_fail = 0;
  int n_compared = 0;
  int n_seen = 0;
  int n_taken = 0;
  logic seen_ok = 1'b0;
  logic [15:0] seen_code = 16'h0000;
  sce_host host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err));
  // short timeout keeps the run brief
  sce_checker #(.TOUT_CYC(50)) dut_u (.clk(clk), .nrst(nrst), .rx_err(rx_err),
    .rx_valid(rx_valid), .rx_data(rx_data), .req_ok(req_ok), .err_valid(err_valid),
    .err_code(err_code), .cmd_out(cmd_out), .addr_out(addr_out), .count_out(count_out));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // latch each one-cycle verdict, so a check that starts late still finds it
  always @(posedge clk) begin
    if (req_ok === 1'b1 || err_valid === 1'b1) begin
      n_seen <= n_seen + 1;
      seen_ok <= req_ok;
      seen_code <= err_code;
    end
  end
  // bounded wait for exactly one new verdict; code 0 means pass
  task verdict(input logic [15:0] code);
    for (int i = 0; i < 200; i++) begin
      #1;
      if (n_seen != n_taken) break;
      @(posedge clk);
    end
    chk(16'(n_seen - n_taken), 16'h0001);
    chk({15'h0000, seen_ok}, {15'h0000, code == 16'h0000});
    chk(seen_code, code);
    n_taken = n_seen;
  endtask
  task t_good();
    repeat (3) @(posedge clk);
    host_u.frame("rs%mw10,2", 1'b0);
    verdict(16'h0000);
    chk({8'h00, cmd_out}, 16'h0072);
    chk(addr_out, 16'h000A);
    chk({8'h00, count_out}, 16'h0002);
    repeat (3) @(posedge clk);
    host_u.frame("rs%mw10,2", 1'b1);
    verdict(16'h6050);
  endtask
  task t_table();
    string ft[17] = '{"ws%mw0,1", "ss%mw0,1", "ys%mw0,9", "xs%mw0,9", "rs%mb0,128",
      "rs%mb0,129", "rs%mw0,0", "zs%mw0,1", "rs%mq0,1", "rd%md0,1", "rs%qx5,1",
      "rs%qx0.0.64,1", "rs%mx00A,1", "rs%mb4000,1", "rb%mx100,1", "ys%mw0,10", "xs%mw0,10"};
    logic [15:0] fc[17] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1232,
      16'h1232, 16'h0021, 16'h2432, 16'h2432, 16'h7132, 16'h2232, 16'h2232, 16'h2232,
      16'h6001, 16'h0290, 16'h0190};
    for (int k = 0; k < 17; k++) begin
      repeat (3) @(posedge clk);
      host_u.frame(ft[k], 1'b0);
      verdict(fc[k]);
    end
  endtask
  task t_stray();
    repeat (3) @(posedge clk);
    host_u.put("r");
    host_u.rest();
    verdict(16'h6030);
  endtask
  task t_fault();
    repeat (3) @(posedge clk);
    host_u.put(8'h05);
    host_u.put("r");
    host_u.rest();
    host_u.fault();
    verdict(16'h6030);
  endtask
  task t_tout();
    repeat (3) @(posedge clk);
    host_u.put(8'h05);
    host_u.put("r");
    host_u.rest();
    verdict(16'h6020);
  endtask
  task t_long();
    repeat (3) @(posedge clk);
    host_u.put(8'h05);
    repeat (257) host_u.put("w");
    host_u.rest();
    verdict(16'h6040);
  endtask
  task give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog, far beyond the several hundred cycles needed
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_good();
    t_table();
    t_stray();
    t_fault();
    t_tout();
    t_long();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
